// file: hw/ishp_pkg.sv
package ishp_pkg;
   localparam logic [6:0] ADDR_ID        = 7'h00;
   localparam logic [6:0] ADDR_RANGE_MAX = 7'h01;
   localparam logic [6:0] ADDR_RANGE_MIN = 7'h02;
   localparam logic [6:0] ADDR_WDT_FREQ  = 7'h03;
   localparam logic [6:0] ADDR_CONV_SET  = 7'h04;
   localparam logic [6:0] ADDR_CLK_CFG   = 7'h05;
   localparam logic [6:0] ADDR_THR_HI_L  = 7'h06;
   localparam logic [6:0] ADDR_THR_HI_H  = 7'h07;
   localparam logic [6:0] ADDR_THR_LO_L  = 7'h08;
   localparam logic [6:0] ADDR_THR_LO_H  = 7'h09;
   localparam logic [6:0] ADDR_IRQ_CFG   = 7'h0a;
   localparam logic [6:0] ADDR_PWR_CFG   = 7'h0b;
   localparam logic [6:0] ADDR_STATUS    = 7'h20;
   localparam logic [6:0] ADDR_PROX_L    = 7'h21;
   localparam logic [6:0] ADDR_PROX_H    = 7'h22;
   localparam logic [6:0] ADDR_CNT_L     = 7'h23;
   localparam logic [6:0] ADDR_CNT_M     = 7'h24;
   localparam logic [6:0] ADDR_CNT_H     = 7'h25;
   // arbitrary neutral identity value
   localparam logic [7:0] RST_ID         = 8'h5a;
   localparam logic [7:0] RST_RANGE_MAX  = 8'h0e;
   localparam logic [7:0] RST_RANGE_MIN  = 8'h14;
   localparam logic [7:0] RST_WDT_FREQ   = 8'h45;
   localparam logic [7:0] RST_CONV_SET   = 8'h1b;
   localparam logic [7:0] RST_CLK_CFG    = 8'h01;
   localparam logic [7:0] RST_THR_HI     = 8'hff;
   localparam logic [7:0] RST_THR_LO     = 8'h00;
   localparam logic [2:0] RST_IRQ_FUNC   = 3'h0;
   localparam int         DIR_BIT        = 7;
   localparam int         PWR_BIT        = 0;
   localparam logic [2:0] FUNC_COMPARE   = 3'h2;
   localparam logic [2:0] FUNC_WAKE      = 3'h1;
   localparam logic [2:0] FUNC_READY     = 3'h4;
   localparam logic [2:0] BIT_LAST       = 3'h7;
   localparam int         CONV_WIN_CYC   = 1000;
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
   } ishp_wr_t;
   typedef struct packed {
      logic [15:0] prox;
      logic [23:0] count;
   } ishp_result_t;
endpackage

// file: hw/ishp_top.sv
`timescale 1ns/1ps
`default_nettype none
module ishp_top
   import ishp_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic         sclk,
   input  wire logic         select_n,
   input  wire logic         sdi,
   output logic              sdo,
   output logic              sdo_oe,
   input  wire logic         timebase_clock_in,
   input  wire logic         osc_in,
   input  wire logic [15:0]  prox_sample,
   output logic              irq_out_n,
   output logic              power_state_select
);
   typedef enum logic [1:0] {S_CMD, S_DATA} ishp_phase_t;

   // ---------------- link domain (sclk) ----------------
   logic        link_rst_n;
   ishp_phase_t phase_ff;
   logic [2:0]  bit_ff;
   logic [6:0]  shift_ff;
   logic [6:0]  addr_ff;
   logic        rd_ff;
   logic        wr_tgl_ff;
   ishp_wr_t    wr_ff;
   logic        rdprox_tgl_ff;
   logic [7:0]  tx_ff;
   logic [7:0]  rd_byte;
   logic        sdo_ff;

   assign link_rst_n = nrst & ~select_n;

   // asynchronous clear on select_n release restarts the command phase
   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         phase_ff <= S_CMD;
         bit_ff   <= 3'h0;
         shift_ff <= 7'h00;
         addr_ff  <= 7'h00;
         rd_ff    <= 1'b0;
      end else begin
         bit_ff   <= bit_ff + 3'h1;
         shift_ff <= {shift_ff[5:0], sdi};
         if (bit_ff == BIT_LAST) begin
            if (phase_ff == S_CMD) begin
               phase_ff <= S_DATA;
               rd_ff    <= shift_ff[DIR_BIT-1];
               addr_ff  <= {shift_ff[5:0], sdi};
            end else begin
               addr_ff <= addr_ff + 7'h01;
            end
         end
      end
   end

   // write commit on the rising edge ending each data byte
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         wr_tgl_ff <= 1'b0;
         wr_ff     <= '0;
      end else if (!select_n && phase_ff == S_DATA && bit_ff == BIT_LAST && !rd_ff) begin
         wr_tgl_ff    <= ~wr_tgl_ff;
         wr_ff.addr   <= addr_ff;
         wr_ff.data   <= {shift_ff, sdi};
      end
   end

   // note a read of the proximity low byte as a toggle event
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         rdprox_tgl_ff <= 1'b0;
      end else if (!select_n && phase_ff == S_DATA && bit_ff == BIT_LAST && rd_ff
                   && addr_ff == ADDR_PROX_L) begin
         rdprox_tgl_ff <= ~rdprox_tgl_ff;
      end
   end

   // falling-edge launch; byte loaded at each byte boundary
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_ff  <= 8'h00;
         sdo_ff <= 1'b0;
      end else if (phase_ff == S_DATA && bit_ff == 3'h0) begin
         tx_ff  <= {rd_byte[6:0], 1'b0};
         sdo_ff <= rd_byte[7];
      end else begin
         tx_ff  <= {tx_ff[6:0], 1'b0};
         sdo_ff <= tx_ff[7];
      end
   end

   assign sdo    = sdo_ff;
   assign sdo_oe = ~select_n & rd_ff & (phase_ff == S_DATA);

   // ---------------- core domain (ref_clk) ----------------
   logic [2:0] wr_sync_ff;
   logic [2:0] rp_sync_ff;
   logic [7:0] range_upper_select_ff;
   logic [7:0] range_lower_select_ff;
   logic [7:0] wdt_freq_ff;
   logic [7:0] converter_settings_ff;
   logic [7:0] clk_cfg_ff;
   logic [15:0] thr_hi_ff;
   logic [15:0] thr_lo_ff;
   logic [2:0] irq_pin_function_ff;
   logic       pwr_ff;
   ishp_result_t res_ff;
   logic       conversion_ready_ff;
   logic       cmp_ff;
   logic       wake_ff;
   logic       wr_evt;
   logic       rp_evt;
   logic       conv_evt;
   ishp_wr_t   wr_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_sync_ff <= 3'h0;
         rp_sync_ff <= 3'h0;
      end else begin
         wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
         rp_sync_ff <= {rp_sync_ff[1:0], rdprox_tgl_ff};
      end
   end
   assign wr_evt = wr_sync_ff[2] ^ wr_sync_ff[1];
   assign rp_evt = rp_sync_ff[2] ^ rp_sync_ff[1];
   // payload is stable for many ref_clk cycles once the toggle has crossed
   assign wr_q   = wr_ff;

   function automatic logic cfg_locked(input logic [6:0] a, input logic act);
      cfg_locked = act && a >= ADDR_RANGE_MAX && a <= ADDR_CLK_CFG;
   endfunction

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         range_upper_select_ff <= RST_RANGE_MAX;
         range_lower_select_ff <= RST_RANGE_MIN;
         wdt_freq_ff           <= RST_WDT_FREQ;
         converter_settings_ff <= RST_CONV_SET;
         clk_cfg_ff            <= RST_CLK_CFG;
         thr_hi_ff             <= {RST_THR_HI, RST_THR_HI};
         thr_lo_ff             <= {RST_THR_LO, RST_THR_LO};
         irq_pin_function_ff   <= RST_IRQ_FUNC;
         pwr_ff                <= 1'b0;
      end else if (wr_evt && !cfg_locked(wr_q.addr, pwr_ff)) begin
         case (wr_q.addr)
            ADDR_RANGE_MAX: range_upper_select_ff <= wr_q.data;
            ADDR_RANGE_MIN: range_lower_select_ff <= wr_q.data;
            ADDR_WDT_FREQ:  wdt_freq_ff           <= wr_q.data;
            ADDR_CONV_SET:  converter_settings_ff <= wr_q.data;
            ADDR_CLK_CFG:   clk_cfg_ff            <= wr_q.data;
            ADDR_THR_HI_L:  thr_hi_ff[7:0]        <= wr_q.data;
            ADDR_THR_HI_H:  thr_hi_ff[15:8]       <= wr_q.data;
            ADDR_THR_LO_L:  thr_lo_ff[7:0]        <= wr_q.data;
            ADDR_THR_LO_H:  thr_lo_ff[15:8]       <= wr_q.data;
            ADDR_IRQ_CFG:   irq_pin_function_ff   <= wr_q.data[2:0];
            ADDR_PWR_CFG:   pwr_ff                <= wr_q.data[PWR_BIT];
            default: ;
         endcase
      end
   end
   assign power_state_select = pwr_ff;

   // ---------------- time-base domain: oscillation counter ----------------
   logic [2:0]  osc_sync_ff;
   logic [23:0] osc_cnt_ff;
   logic [15:0] tb_win_ff;
   logic        tb_tgl_ff;
   logic [23:0] tb_cnt_ff;
   logic [2:0]  tb_sync_ff;
   logic [2:0]  pw_sync_ff;

   always_ff @(posedge timebase_clock_in or negedge nrst) begin
      if (!nrst) begin
         pw_sync_ff <= 3'h0;
         osc_sync_ff <= 3'h0;
         osc_cnt_ff <= 24'h0;
         tb_win_ff  <= 16'h0;
         tb_tgl_ff  <= 1'b0;
         tb_cnt_ff  <= 24'h0;
      end else begin
         pw_sync_ff  <= {pw_sync_ff[1:0], pwr_ff};
         osc_sync_ff <= {osc_sync_ff[1:0], osc_in};
         if (!pw_sync_ff[2]) begin
            tb_win_ff  <= 16'h0;
            osc_cnt_ff <= 24'h0;
         end else if (tb_win_ff == 16'(CONV_WIN_CYC - 1)) begin
            tb_win_ff  <= 16'h0;
            osc_cnt_ff <= 24'h0;
            tb_cnt_ff  <= osc_cnt_ff;
            tb_tgl_ff  <= ~tb_tgl_ff;
         end else begin
            tb_win_ff <= tb_win_ff + 16'h1;
            if (osc_sync_ff[2] ^ osc_sync_ff[1])
               osc_cnt_ff <= osc_cnt_ff + 24'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tb_sync_ff <= 3'h0;
      end else begin
         tb_sync_ff <= {tb_sync_ff[1:0], tb_tgl_ff};
      end
   end
   assign conv_evt = tb_sync_ff[2] ^ tb_sync_ff[1];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         res_ff <= '0;
      end else if (conv_evt && pwr_ff) begin
         res_ff.prox  <= prox_sample;
         res_ff.count <= tb_cnt_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmp_ff              <= 1'b0;
         wake_ff             <= 1'b0;
         conversion_ready_ff <= 1'b0;
      end else begin
         if (res_ff.prox > thr_hi_ff)
            cmp_ff <= 1'b1;
         else if (res_ff.prox < thr_lo_ff)
            cmp_ff <= 1'b0;
         if (irq_pin_function_ff != FUNC_WAKE)
            wake_ff <= 1'b0;
         else if (res_ff.prox > thr_hi_ff)
            wake_ff <= 1'b1;
         if (conv_evt && pwr_ff)
            conversion_ready_ff <= 1'b1;
         else if (rp_evt)
            conversion_ready_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_out_n <= 1'b1;
      end else begin
         case (irq_pin_function_ff)
            FUNC_COMPARE: irq_out_n <= ~cmp_ff;
            FUNC_WAKE:    irq_out_n <= ~wake_ff;
            FUNC_READY:   irq_out_n <= ~conversion_ready_ff;
            default:      irq_out_n <= 1'b1;
         endcase
      end
   end

   // read mux (words stable between conversions)
   always_comb begin
      case (addr_ff)
         ADDR_ID:        rd_byte = RST_ID;
         ADDR_RANGE_MAX: rd_byte = range_upper_select_ff;
         ADDR_RANGE_MIN: rd_byte = range_lower_select_ff;
         ADDR_WDT_FREQ:  rd_byte = wdt_freq_ff;
         ADDR_CONV_SET:  rd_byte = converter_settings_ff;
         ADDR_CLK_CFG:   rd_byte = clk_cfg_ff;
         ADDR_THR_HI_L:  rd_byte = thr_hi_ff[7:0];
         ADDR_THR_HI_H:  rd_byte = thr_hi_ff[15:8];
         ADDR_THR_LO_L:  rd_byte = thr_lo_ff[7:0];
         ADDR_THR_LO_H:  rd_byte = thr_lo_ff[15:8];
         ADDR_IRQ_CFG:   rd_byte = {5'h00, irq_pin_function_ff};
         ADDR_PWR_CFG:   rd_byte = {7'h00, pwr_ff};
         ADDR_STATUS:    rd_byte = {1'b0, conversion_ready_ff, wake_ff, cmp_ff, 4'h0};
         ADDR_PROX_L:    rd_byte = res_ff.prox[7:0];
         ADDR_PROX_H:    rd_byte = res_ff.prox[15:8];
         ADDR_CNT_L:     rd_byte = res_ff.count[7:0];
         ADDR_CNT_M:     rd_byte = res_ff.count[15:8];
         ADDR_CNT_H:     rd_byte = res_ff.count[23:16];
         default:        rd_byte = 8'h00;
      endcase
   end

   // assertions
   property p_idle_irq;
      @(posedge ref_clk) disable iff (!nrst)
         (irq_pin_function_ff != FUNC_COMPARE && irq_pin_function_ff != FUNC_WAKE &&
          irq_pin_function_ff != FUNC_READY) |=> irq_out_n;
   endproperty
   a_idle_irq: assert property (p_idle_irq) else $error("irq active with no function");

   property p_lock;
      @(posedge ref_clk) disable iff (!nrst)
         pwr_ff && $past(pwr_ff) |-> $stable(range_upper_select_ff);
   endproperty
   a_lock: assert property (p_lock) else $error("locked register changed");

   property p_wake_hold;
      @(posedge ref_clk) disable iff (!nrst)
         wake_ff && irq_pin_function_ff == FUNC_WAKE |=> wake_ff;
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake released early");

   property p_standby;
      @(posedge ref_clk) disable iff (!nrst)
         !pwr_ff |=> $stable(res_ff);
   endproperty
   a_standby: assert property (p_standby) else $error("conversion in standby");

   property p_lock_conv;
      @(posedge ref_clk) disable iff (!nrst)
         pwr_ff && $past(pwr_ff) |-> $stable(converter_settings_ff);
   endproperty
   a_lock_conv: assert property (p_lock_conv) else $error("locked settings changed");

   property p_cmp_set;
      @(posedge ref_clk) disable iff (!nrst)
         res_ff.prox > thr_hi_ff |=> cmp_ff;
   endproperty
   a_cmp_set: assert property (p_cmp_set) else $error("comparator not set above high");

   property p_cmp_clr;
      @(posedge ref_clk) disable iff (!nrst)
         res_ff.prox < thr_lo_ff && res_ff.prox <= thr_hi_ff |=> !cmp_ff;
   endproperty
   a_cmp_clr: assert property (p_cmp_clr) else $error("comparator not cleared below low");

   property p_ready_set;
      @(posedge ref_clk) disable iff (!nrst)
         conv_evt && pwr_ff |=> conversion_ready_ff;
   endproperty
   a_ready_set: assert property (p_ready_set) else $error("ready flag missed new data");

   property p_ready_pin;
      @(posedge ref_clk) disable iff (!nrst)
         irq_pin_function_ff == FUNC_READY |=> irq_out_n == !$past(conversion_ready_ff);
   endproperty
   a_ready_pin: assert property (p_ready_pin) else $error("irq pin not following ready");

   property p_wake_pin;
      @(posedge ref_clk) disable iff (!nrst)
         irq_pin_function_ff == FUNC_WAKE && wake_ff |=> !irq_out_n;
   endproperty
   a_wake_pin: assert property (p_wake_pin) else $error("irq pin not showing wake");

   property p_wr_commit;
      @(posedge sclk) disable iff (!nrst)
         !select_n && phase_ff == S_DATA && bit_ff == BIT_LAST && !rd_ff
         |=> wr_tgl_ff != $past(wr_tgl_ff);
   endproperty
   a_wr_commit: assert property (p_wr_commit) else $error("byte end did not commit");
endmodule
`default_nettype wire

// file: tb/ishp_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module ishp_spi_master (
   output logic      sclk,
   output logic      select_n,
   output logic      sdi,
   input  wire logic sdo
);
   logic [7:0] tx [8];
   logic [7:0] rx [8];
   int         gap_ns = 0;
   initial begin
      sclk = 1'b0;
      select_n = 1'b1;
      sdi = 1'b0;
   end
   // one framed access, clock idles low; cut stops the clocks early
   task automatic xfer(input logic [7:0] cmd, input int nb, input int cut);
      logic [7:0] sh;
      select_n = 1'b0;
      #40;
      for (int k = 0; k < 8 * (nb + 1) && k < cut; k++) begin
         if (k < 8) begin
            sh = cmd;
         end else begin
            sh = tx[k/8-1];
         end
         sdi = sh[7 - k % 8];
         #62.5 sclk = 1'b1;
         if (k >= 8) begin
            rx[k/8-1][7 - k % 8] = sdo;
         end
         #62.5 sclk = 1'b0;
         if (k % 8 == 7) begin
            #(gap_ns);
         end
      end
      #40 select_n = 1'b1;
      sdi = ~sdi;
      #100;
   endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ishp_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        tb_clk = 1'b0;
   logic        osc_in = 1'b0;
   logic [15:0] prox_sample = 16'h0000;
   logic        sclk, select_n, sdi, sdo, sdo_oe, irq_out_n, power_state_select;
   int          fails = 0;
   int          n_tests = 0;
   int          oe_cnt = 0;
   logic [7:0]  exp0 [6] = '{RST_ID, RST_RANGE_MAX, RST_RANGE_MIN,
                             RST_WDT_FREQ, RST_CONV_SET, RST_CLK_CFG};
   logic [7:0]  thr [4] = '{8'ha5, 8'h10, 8'h00, 8'h08};
   logic [7:0]  keep [5];
   int          cuts [2] = '{12, 15};

   always #5 ref_clk = ~ref_clk;
   always #62.5 tb_clk = ~tb_clk;
   // counts rising sclk edges at which the device drives sdo
   always @(posedge sclk) begin
      if (!select_n && sdo_oe) oe_cnt++;
   end
   always begin
      repeat (50) @(negedge ref_clk);
      osc_in <= ~osc_in;
   end

   ishp_top i_dut (
      .ref_clk            (ref_clk),
      .nrst               (nrst),
      .sclk               (sclk),
      .select_n           (select_n),
      .sdi                (sdi),
      .sdo                (sdo),
      .sdo_oe             (sdo_oe),
      .timebase_clock_in  (tb_clk),
      .osc_in             (osc_in),
      .prox_sample        (prox_sample),
      .irq_out_n          (irq_out_n),
      .power_state_select (power_state_select)
   );
   ishp_spi_master i_master (
      .sclk     (sclk),
      .select_n (select_n),
      .sdi      (sdi),
      .sdo      (sdo)
   );

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input int nb, input int cut);
      i_master.xfer({1'b0, a}, nb, cut);
   endtask
   task automatic rd(input logic [6:0] a, input int nb);
      i_master.xfer({1'b1, a}, nb, 999);
   endtask
   task automatic setp(input logic [15:0] v);
      @(negedge ref_clk);
      prox_sample <= v;
   endtask
   task automatic conv();
      repeat (CONV_WIN_CYC * 13) @(negedge ref_clk);
   endtask
   task automatic fn(input logic [2:0] f);
      i_master.tx[0] = {5'h00, f};
      wr(ADDR_IRQ_CFG, 1, 999);
      repeat (10) @(negedge ref_clk);
   endtask
   task automatic pwr(input logic on);
      i_master.tx[0] = {7'h00, on};
      wr(ADDR_PWR_CFG, 1, 999);
      repeat (10) @(negedge ref_clk);
      chk("power_state_select", {7'h00, on}, {7'h00, power_state_select});
   endtask
   task automatic wait_irq(input logic lvl);
      int c;
      c = 0;
      while (irq_out_n !== lvl && c < 40000) begin
         @(negedge ref_clk);
         c++;
      end
      chk("irq_out_n", {7'h00, lvl}, {7'h00, irq_out_n});
      if (c == 40000) complete_run();
   endtask

   initial begin
      repeat (10) @(negedge ref_clk);
      nrst <= 1'b1;
      repeat (5) @(negedge ref_clk);
      chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
      chk("power_state_select", 8'h00, {7'h00, power_state_select});
      chk("sdo_oe", 8'h00, {7'h00, sdo_oe});
      rd(ADDR_ID, 6);
      foreach (exp0[i]) chk("reset_reg", exp0[i], i_master.rx[i]);
      chk("sdo_oe_cycles", 8'h30, 8'(oe_cnt));
      // single write, then slow extended write over the thresholds
      i_master.tx[0] = thr[0];
      wr(ADDR_THR_HI_L, 1, 999);
      chk("sdo_oe_cycles", 8'h30, 8'(oe_cnt));
      foreach (thr[i]) i_master.tx[i] = thr[(i + 1) % 4];
      i_master.gap_ns = 500;
      wr(ADDR_THR_HI_H, 3, 999);
      i_master.gap_ns = 0;
      rd(ADDR_THR_HI_L, 4);
      foreach (thr[i]) chk("threshold", thr[i], i_master.rx[i]);
      // frames cut short must not write
      foreach (cuts[j]) begin
         i_master.tx[0] = 8'h3c;
         wr(ADDR_THR_HI_L, 1, cuts[j]);
         rd(ADDR_THR_HI_L, 1);
         chk("aborted_write", thr[0], i_master.rx[0]);
      end
      pwr(1'b1);
      i_master.tx[0] = 8'h33;
      wr(ADDR_RANGE_MAX, 1, 999);
      rd(ADDR_RANGE_MAX, 1);
      chk("range_upper_select", RST_RANGE_MAX, i_master.rx[0]);
      // wake-up: holds after the result drops until disabled
      setp(16'h2000);
      fn(FUNC_WAKE);
      wait_irq(1'b0);
      setp(16'h0400);
      conv();
      chk("irq_out_n", 8'h00, {7'h00, irq_out_n});
      fn(3'h0);
      chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
      // comparator with hysteresis, starting below the low threshold
      fn(FUNC_COMPARE);
      chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
      setp(16'h2000);
      wait_irq(1'b0);
      setp(16'h0900);
      conv();
      chk("irq_out_n", 8'h00, {7'h00, irq_out_n});
      setp(16'h0400);
      wait_irq(1'b1);
      // conversion ready, cleared by the proximity low read
      setp(16'h1234);
      fn(FUNC_READY);
      // flag left over from earlier conversions is cleared by a low-byte read
      rd(ADDR_PROX_L, 1);
      chk("proximity_low_byte", 8'h00, i_master.rx[0]);
      repeat (10) @(negedge ref_clk);
      chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
      wait_irq(1'b0);
      rd(ADDR_PROX_L, 5);
      repeat (10) @(negedge ref_clk);
      chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
      chk("proximity_low_byte", 8'h34, i_master.rx[0]);
      chk("proximity_high_byte", 8'h12, i_master.rx[1]);
      // standby freezes results; burst and single reads agree
      pwr(1'b0);
      setp(16'h5555);
      conv();
      rd(ADDR_PROX_L, 5);
      foreach (keep[i]) keep[i] = i_master.rx[i];
      chk("proximity_low_byte", 8'h34, keep[0]);
      for (int i = 0; i < 3; i++) begin
         rd(ADDR_CNT_L + 7'(i), 1);
         chk("osc_count", keep[i + 2], i_master.rx[0]);
      end
      complete_run();
   end
endmodule
`default_nettype wire
